//--- design/dtipd_cfg_ram.sv
// Purpose: per channel route and level configuration store
// Assumes: one write or read per clock, index is channel number
// Notes: unused channels drop writes and read zero, except the spurious entry, which reads CFG_SPURIOUS
`timescale 1ns/1ps
`default_nettype none
module dtipd_cfg_ram
  import dtipd_pkg::*;
(
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // access
  input  wire logic                  cfg_wr,
  input  wire logic [CH_W-1:0]       cfg_idx,
  input  wire logic [7:0]            cfg_wdata,
  output var  logic [7:0]            cfg_rdata,
  // flat view
  output wire logic [N_CH-1:0]       route,
  output wire logic [N_CH*LVL_W-1:0] lvl
);
  // unpacked so each entry has its own writer process
  logic [7:0] mem [N_CH];

  function automatic logic ch_used(input logic [CH_W-1:0] c);
    return (c >= CH_FIRST && c <= CH_LAST);
  endfunction

  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_ch
      always_ff @(posedge mclk) begin
        if (reset) begin
          mem[g] <= ch_used(CH_W'(g)) ? CFG_RESET : 8'h00;
        end else if (cfg_wr && cfg_idx == CH_W'(g) && ch_used(CH_W'(g))) begin
          mem[g] <= {cfg_wdata[CFG_ROUTE_BIT], 4'h0, cfg_wdata[LVL_W-1:0]};
        end
      end
      assign route[g] = mem[g][CFG_ROUTE_BIT];
      assign lvl[g*LVL_W +: LVL_W] = mem[g][LVL_W-1:0];
    end
  endgenerate

  // spurious entry is fixed and write-protected
  assign cfg_rdata = (cfg_idx == CH_SPURIOUS) ? CFG_SPURIOUS :
                     mem[cfg_idx];
endmodule
`default_nettype wire

//--- design/dtipd_pkg.sv
// Purpose: constants and types for the dual target irq priority decoder
// Assumes: one clock mclk at 40 MHz, synchronous active high reset
// Notes: channel n sits at vector offset 2*n from the vector base
package dtipd_pkg;
  localparam int unsigned N_CH        = 128;
  localparam int unsigned CH_W        = 7;
  localparam int unsigned LVL_W       = 3;
  localparam logic [LVL_W-1:0] LVL_ZERO  = 3'h0;
  localparam logic [LVL_W-1:0] LVL_RESET = 3'h1;
  localparam logic [LVL_W-1:0] LVL_MAX   = 3'h7;
  localparam logic [7:0]  CFG_RESET      = 8'h01;
  localparam logic [7:0]  CFG_SPURIOUS   = 8'h07;
  localparam int unsigned CFG_ROUTE_BIT  = 7;
  // vector offsets
  localparam logic [15:0] OFS_SPURIOUS   = 16'h0010;
  localparam logic [15:0] OFS_SYS        = 16'h0012;
  localparam logic [15:0] OFS_CPU_VIOL   = 16'h0014;
  localparam logic [15:0] OFS_COP_VIOL   = 16'h0016;
  localparam logic [15:0] OFS_NMI_EXT    = 16'h00f4;
  localparam logic [15:0] OFS_SWI        = 16'h00f6;
  localparam logic [15:0] OFS_TRAP       = 16'h00f8;
  localparam logic [15:0] OFS_MASK_TOP   = 16'h00f2;
  localparam logic [CH_W-1:0] CH_SPURIOUS = 7'h08;
  localparam logic [CH_W-1:0] CH_FIRST    = 7'h0d;
  localparam logic [CH_W-1:0] CH_LAST     = 7'h79;
  localparam logic [15:0] VEC_RST_PIN    = 16'hfffe;
  localparam logic [15:0] VEC_RST_CLK    = 16'hfffc;
  localparam logic [15:0] VEC_RST_WDOG   = 16'hfffa;
  localparam logic [15:0] VEC_BASE_RESET = 16'hff00;

  typedef enum logic [1:0] {
    DTIPD_RST_PIN, DTIPD_RST_CLK, DTIPD_RST_WDOG, DTIPD_RST_NONE
  } dtipd_rst_t;
endpackage

//--- design/dtipd_prio_enc.sv
// Purpose: one ranking tree, highest level then highest channel
// Assumes: levels of disallowed channels arrive as zero
// Notes: purely combinational, instanced once per target
`timescale 1ns/1ps
`default_nettype none
module dtipd_prio_enc
  import dtipd_pkg::*;
(
  // candidates
  input  wire logic [N_CH*LVL_W-1:0] lvl_flat,
  // winner
  output var  logic                  found,
  output var  logic [CH_W-1:0]       win_ch,
  output var  logic [LVL_W-1:0]      win_lvl
);
  always_comb begin
    logic [LVL_W-1:0] l;
    found   = 1'b0;
    win_ch  = '0;
    win_lvl = LVL_ZERO;
    l       = LVL_ZERO;
    // ascending scan with >= lets the higher channel win ties
    for (int i = 0; i < N_CH; i++) begin
      l = lvl_flat[i*LVL_W +: LVL_W];
      if (l != LVL_ZERO && l >= win_lvl) begin
        found   = 1'b1;
        win_ch  = CH_W'(i);
        win_lvl = l;
      end
    end
  end
endmodule
`default_nettype wire

//--- design/dtipd_top.sv
// Purpose: ranks maskable channels for cpu and coprocessor targets
// Assumes: requests held by sources until service starts
// Notes: vector resolved in the cycle cpu_vec_req is seen
`timescale 1ns/1ps
`default_nettype none
module dtipd_top
  import dtipd_pkg::*;
(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // channel requests, local enables already applied by peripherals
  input  wire logic [N_CH-1:0]   chan_req,
  input  wire logic [N_CH-1:0]   coproc_chan_flag,
  input  wire logic              coproc_irq_enable,
  input  wire logic [LVL_W-1:0]  coproc_shared_priority,
  // configuration access
  input  wire logic [15:0]       vec_base,
  input  wire logic              cfg_wr,
  input  wire logic [CH_W-1:0]   cfg_idx,
  input  wire logic [7:0]        cfg_wdata,
  output logic      [7:0]        cfg_rdata,
  // cpu condition code state
  input  wire logic              irq_mask,
  input  wire logic [LVL_W-1:0]  current_processing_level,
  // nonmaskable sources
  input  wire logic              trap_request,
  input  wire logic              software_irq_instr,
  input  wire logic              debug_vector_request,
  input  wire logic              system_call_instr,
  input  wire logic              cpu_access_violation,
  input  wire logic              coproc_access_violation,
  input  wire logic              nonmaskable_ext_request,
  input  wire logic              nonmaskable_ext_mask,
  // reset request types
  input  wire logic              rst_req_pin,
  input  wire logic              rst_req_clkmon,
  input  wire logic              watchdog_reset,
  input  wire logic              reset_vec_req,
  // cpu vector handshake
  input  wire logic              cpu_vec_req,
  output logic                   cpu_irq,
  output logic                   cpu_vec_valid,
  output logic      [15:0]       cpu_vec,
  output logic                   cpu_lvl_load,
  output logic      [LVL_W-1:0]  cpu_new_level,
  output logic      [1:0]        reset_kind,
  // coprocessor request
  output logic                   coproc_req,
  output logic      [CH_W-1:0]   coproc_ch,
  output logic                   coproc_urgent
);
  typedef struct packed {
    logic              cpu_irq;
    logic              cpu_vec_valid;
    logic [15:0]       cpu_vec;
    logic              cpu_lvl_load;
    logic [LVL_W-1:0]  cpu_new_level;
    logic [1:0]        reset_kind;
    logic              coproc_req;
    logic [CH_W-1:0]   coproc_ch;
    logic              coproc_urgent;
    logic [7:0]        cfg_rdata;
  } dtipd_state_t;

  dtipd_state_t st;
  dtipd_state_t next_st;

  logic [N_CH-1:0]       route;
  logic [N_CH*LVL_W-1:0] lvl;
  logic [7:0]            ram_rdata;
  wire logic [N_CH*LVL_W-1:0] cpu_lvl;
  wire logic [N_CH*LVL_W-1:0] cop_lvl;
  logic                  cpu_found;
  logic [CH_W-1:0]       cpu_ch;
  logic [LVL_W-1:0]      cpu_win_lvl;
  logic                  cop_found;
  logic [CH_W-1:0]       cop_ch;
  logic [LVL_W-1:0]      cop_win_lvl;
  logic                  nm_pending;
  logic [15:0]           nm_ofs;

  dtipd_cfg_ram u_cfg (
    .mclk      (mclk),
    .reset     (reset),
    .cfg_wr    (cfg_wr),
    .cfg_idx   (cfg_idx),
    .cfg_wdata (cfg_wdata),
    .cfg_rdata (ram_rdata),
    .route     (route),
    .lvl       (lvl)
  );

  // candidate levels per target, zero where not eligible
  genvar g;
  generate
    for (g = 0; g < N_CH; g++) begin : g_cand
      logic [LVL_W-1:0] l;
      logic             cpu_ok;
      logic             cop_irq;
      assign l = lvl[g*LVL_W +: LVL_W];
      // coprocessor flag raises cpu irq at shared priority
      assign cop_irq = coproc_chan_flag[g] && coproc_irq_enable &&
                       route[g];
      assign cpu_ok = (chan_req[g] && !route[g] && l != LVL_ZERO &&
                       l > current_processing_level) ||
                      (cop_irq && coproc_shared_priority >
                       current_processing_level);
      assign cpu_lvl[g*LVL_W +: LVL_W] =
        !cpu_ok ? LVL_ZERO :
        (cop_irq && !(chan_req[g] && !route[g])) ?
        coproc_shared_priority : l;
      assign cop_lvl[g*LVL_W +: LVL_W] =
        (chan_req[g] && route[g]) ? l : LVL_ZERO;
    end
  endgenerate

  // two independent decoders
  dtipd_prio_enc u_cpu_enc (
    .lvl_flat (cpu_lvl),
    .found    (cpu_found),
    .win_ch   (cpu_ch),
    .win_lvl  (cpu_win_lvl)
  );

  dtipd_prio_enc u_cop_enc (
    .lvl_flat (cop_lvl),
    .found    (cop_found),
    .win_ch   (cop_ch),
    .win_lvl  (cop_win_lvl)
  );

  // fixed nonmaskable ranking, trap highest
  always_comb begin
    nm_pending = 1'b1;
    nm_ofs     = OFS_SPURIOUS;
    if (trap_request) begin
      nm_ofs = OFS_TRAP;
    end else if (software_irq_instr || debug_vector_request) begin
      nm_ofs = OFS_SWI;
    end else if (system_call_instr) begin
      nm_ofs = OFS_SYS;
    end else if (coproc_access_violation) begin
      nm_ofs = OFS_COP_VIOL;
    end else if (cpu_access_violation) begin
      nm_ofs = OFS_CPU_VIOL;
    end else if (nonmaskable_ext_request && !nonmaskable_ext_mask) begin
      nm_ofs = OFS_NMI_EXT;
    end else begin
      nm_pending = 1'b0;
    end
  end

  always_comb begin
    next_st               = st;
    next_st.cpu_vec_valid = 1'b0;
    next_st.cpu_lvl_load  = 1'b0;
    next_st.cfg_rdata     = ram_rdata;
    // irq line tracks qualification each cycle
    next_st.cpu_irq = nm_pending || (cpu_found && !irq_mask);
    if (reset_vec_req) begin
      // reset vectors are absolute and ranked pin, clock, watchdog
      next_st.cpu_vec_valid = 1'b1;
      if (rst_req_pin) begin
        next_st.cpu_vec    = VEC_RST_PIN;
        next_st.reset_kind = DTIPD_RST_PIN;
      end else if (rst_req_clkmon) begin
        next_st.cpu_vec    = VEC_RST_CLK;
        next_st.reset_kind = DTIPD_RST_CLK;
      end else if (watchdog_reset) begin
        next_st.cpu_vec    = VEC_RST_WDOG;
        next_st.reset_kind = DTIPD_RST_WDOG;
      end else begin
        next_st.cpu_vec    = VEC_RST_PIN;
        next_st.reset_kind = DTIPD_RST_PIN;
      end
    end else if (cpu_vec_req) begin
      // sampled now, so a later stronger request waits for the next fetch
      next_st.cpu_vec_valid = 1'b1;
      if (nm_pending) begin
        next_st.cpu_vec = vec_base + nm_ofs;
      end else if (cpu_found && !irq_mask) begin
        next_st.cpu_vec       = vec_base + {8'h00, cpu_ch, 1'b0};
        next_st.cpu_lvl_load  = 1'b1;
        next_st.cpu_new_level = cpu_win_lvl;
      end else begin
        next_st.cpu_vec = vec_base + OFS_SPURIOUS;
      end
    end
    // coprocessor side ignores its thread level
    next_st.coproc_req    = cop_found;
    next_st.coproc_ch     = cop_ch;
    next_st.coproc_urgent = cop_found && cop_win_lvl[LVL_W-1];
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st            <= '0;
      st.cpu_vec    <= VEC_RST_PIN;
      st.reset_kind <= DTIPD_RST_NONE;
    end else begin
      st <= next_st;
    end
  end

  assign cpu_irq       = st.cpu_irq;
  assign cpu_vec_valid = st.cpu_vec_valid;
  assign cpu_vec       = st.cpu_vec;
  assign cpu_lvl_load  = st.cpu_lvl_load;
  assign cpu_new_level = st.cpu_new_level;
  assign reset_kind    = st.reset_kind;
  assign coproc_req    = st.coproc_req;
  assign coproc_ch     = st.coproc_ch;
  assign coproc_urgent = st.coproc_urgent;
  assign cfg_rdata     = st.cfg_rdata;
endmodule
`default_nettype wire

//--- tb/dtipd_cpu_model.sv
// Purpose: cpu side of the vector fetch with a level stack
// Assumes: bench asks for a fetch, cpu_vec_req follows one cycle later
// Notes: stack of eight, deeper nesting wraps
`timescale 1ns/1ps
`default_nettype none
module dtipd_cpu_model
  import dtipd_pkg::*;
(
  // clock and reset
  input  wire logic             mclk,
  input  wire logic             reset,
  // bench commands
  input  wire logic             fetch,
  input  wire logic             return_from_irq_instr,
  // decoder side
  input  wire logic             cpu_lvl_load,
  input  wire logic [LVL_W-1:0] cpu_new_level,
  output var  logic             cpu_vec_req,
  output var  logic [LVL_W-1:0] cpl
);
  logic [LVL_W-1:0] stk [8];
  logic [2:0]       sp;
  always_ff @(posedge mclk) begin
    cpu_vec_req <= fetch & ~reset;
    if (reset) begin
      cpl <= 3'h0;
      sp  <= 3'h0;
    end else if (cpu_lvl_load) begin
      stk[sp] <= cpl;
      sp      <= sp + 3'h1;
      cpl     <= cpu_new_level;
    end else if (return_from_irq_instr) begin
      sp  <= sp - 3'h1;
      cpl <= stk[sp-3'h1];
    end
  end
endmodule
`default_nettype wire

//--- tb/dtipd_props.sv
// Purpose: handshake and reset vector checks for dtipd_top
// Assumes: single clock, synchronous active high reset
// Notes: bound to the top, sees its ports only
`timescale 1ns/1ps
`default_nettype none
module dtipd_props
  import dtipd_pkg::*;
(
  // clock and reset
  input wire logic             mclk,
  input wire logic             reset,
  // requests
  input wire logic             cpu_vec_req,
  input wire logic             reset_vec_req,
  input wire logic             rst_req_pin,
  input wire logic             rst_req_clkmon,
  input wire logic             watchdog_reset,
  // answers
  input wire logic             cpu_vec_valid,
  input wire logic [15:0]      cpu_vec,
  input wire logic             cpu_lvl_load,
  input wire logic [LVL_W-1:0] cpu_new_level,
  input wire logic [1:0]       reset_kind
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  wire logic take = cpu_vec_req | reset_vec_req;
  a_vec_answered: assert property (take |=> cpu_vec_valid)
    else $error("vector request not answered");
  a_no_stray_vec: assert property (!take |=> !cpu_vec_valid)
    else $error("vector valid without request");
  a_vec_held: assert property (!take |=> $stable(cpu_vec))
    else $error("vector changed without request");
  a_load_with_vec: assert property (cpu_lvl_load |-> cpu_vec_valid)
    else $error("level load outside vector fetch");
  a_load_nonzero: assert property (cpu_lvl_load |-> |cpu_new_level)
    else $error("zero level loaded");
  a_rst_pin_first: assert property (reset_vec_req && rst_req_pin
    |=> cpu_vec == VEC_RST_PIN && reset_kind == 2'h0)
    else $error("pin reset vector wrong");
  a_rst_clk_next: assert property (reset_vec_req && !rst_req_pin
    && rst_req_clkmon |=> cpu_vec == VEC_RST_CLK && reset_kind == 2'h1)
    else $error("clock monitor reset vector wrong");
  a_rst_wdog_last: assert property (reset_vec_req && !rst_req_pin
    && !rst_req_clkmon && watchdog_reset
    |=> cpu_vec == VEC_RST_WDOG && reset_kind == 2'h2)
    else $error("watchdog reset vector wrong");
endmodule
bind dtipd_top dtipd_props chk_u (
  .mclk, .reset, .cpu_vec_req, .reset_vec_req, .rst_req_pin,
  .rst_req_clkmon, .watchdog_reset, .cpu_vec_valid, .cpu_vec,
  .cpu_lvl_load, .cpu_new_level, .reset_kind
);
`default_nettype wire

//--- tb/test_dual_target_irq_priority_decoder.sv
// Purpose: directed bench for the dual target irq priority decoder
// Assumes: vec_base fixed, sources keep requests held even after fetch
// Notes: ext nonmaskable mask stepped once, coprocessor thread at level 2
`timescale 1ns/1ps
`default_nettype none
module test_dual_target_irq_priority_decoder
  import dtipd_pkg::*;
;
  logic             mclk = 1'b0;
  logic             reset = 1'b1;
  logic [N_CH-1:0]  chan_req = '0;
  logic [N_CH-1:0]  coproc_chan_flag = '0;
  logic             coproc_irq_enable = 1'b0;
  logic [LVL_W-1:0] coproc_shared_priority = 3'h0;
  logic [15:0]      vec_base = VEC_BASE_RESET;
  logic             cfg_wr = 1'b0;
  logic [CH_W-1:0]  cfg_idx = 7'h00;
  logic [7:0]       cfg_wdata = 8'h00;
  logic             irq_mask = 1'b0;
  logic [6:0]       nms = 7'h00;
  logic             nm_mask = 1'b0;
  logic [LVL_W-1:0] thread_lvl = 3'h2;
  logic [2:0]       rst_src = 3'h0;
  logic             reset_vec_req = 1'b0;
  logic             fetch = 1'b0;
  logic             return_from_irq_instr = 1'b0;
  logic             cpu_vec_req, cpu_irq, cpu_vec_valid, cpu_lvl_load;
  logic             coproc_req, coproc_urgent;
  logic [7:0]       cfg_rdata;
  logic [15:0]      cpu_vec;
  logic [LVL_W-1:0] cpu_new_level, current_processing_level;
  logic [1:0]       reset_kind;
  logic [CH_W-1:0]  coproc_ch;
  int               mismatches = 0, checks_done = 0, cycles = 0;
  localparam logic [15:0] NM_OFS [7] = '{OFS_TRAP, OFS_SWI, OFS_SWI,
    OFS_SYS, OFS_CPU_VIOL, OFS_COP_VIOL, OFS_NMI_EXT};
  localparam logic [15:0] RST_VEC [3] = '{VEC_RST_PIN, VEC_RST_CLK,
    VEC_RST_WDOG};
  dtipd_top dut_u (
    .mclk, .reset, .chan_req, .coproc_chan_flag, .coproc_irq_enable,
    .coproc_shared_priority, .vec_base, .cfg_wr, .cfg_idx, .cfg_wdata,
    .cfg_rdata, .irq_mask, .current_processing_level,
    .trap_request(nms[0]), .software_irq_instr(nms[1]),
    .debug_vector_request(nms[2]), .system_call_instr(nms[3]),
    .cpu_access_violation(nms[4]), .coproc_access_violation(nms[5]),
    .nonmaskable_ext_request(nms[6]), .nonmaskable_ext_mask(nm_mask),
    .rst_req_pin(rst_src[0]), .rst_req_clkmon(rst_src[1]),
    .watchdog_reset(rst_src[2]), .reset_vec_req, .cpu_vec_req, .cpu_irq,
    .cpu_vec_valid, .cpu_vec, .cpu_lvl_load, .cpu_new_level, .reset_kind,
    .coproc_req, .coproc_ch, .coproc_urgent
  );
  dtipd_cpu_model cpu_u (
    .mclk, .reset, .fetch, .return_from_irq_instr, .cpu_lvl_load, .cpu_new_level,
    .cpu_vec_req, .cpl(current_processing_level)
  );
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // generous ceiling, the run needs under a hundred cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      final_report();
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task automatic chk(input string what, input logic [15:0] e, g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("FAIL %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chkb(input string what, input logic e, g);
    chk(what, {15'h0, e}, {15'h0, g});
  endtask
  task automatic cfg(input logic [6:0] ch, input logic [7:0] d);
    cfg_idx = ch;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    tick(1);
    cfg_wr = 1'b0;
    // idle edge, back-to-back writes must see the strobe drop
    tick(1);
  endtask
  task automatic rdc(input logic [6:0] ch, input logic [7:0] d);
    cfg_idx = ch;
    tick(1);
    chk("cfg_rdata", {8'h00, d}, {8'h00, cfg_rdata});
  endtask
  // zero level means no load expected
  task automatic vec(input logic [15:0] v, input logic [2:0] l);
    fetch = 1'b1;
    tick(1);
    fetch = 1'b0;
    tick(1);
    chkb("cpu_vec_valid", 1'b1, cpu_vec_valid);
    chk("cpu_vec", v, cpu_vec);
    chkb("cpu_lvl_load", |l, cpu_lvl_load);
    if (|l) chk("cpu_new_level", {13'h0, l}, {13'h0, cpu_new_level});
  endtask
  // a tick first, a load in flight would hide the return
  task automatic ret();
    tick(1);
    return_from_irq_instr = 1'b1;
    tick(1);
    return_from_irq_instr = 1'b0;
  endtask
  initial begin
    tick(6);
    reset = 1'b0;
    chk("cpu_vec", VEC_RST_PIN, cpu_vec);
    chk("reset_kind", 16'h0003, {14'h0, reset_kind});
    rdc(7'h0d, CFG_RESET);
    rdc(7'h79, CFG_RESET);
    rdc(7'h7a, 8'h00);
    cfg(7'h08, 8'h00);
    rdc(7'h08, CFG_SPURIOUS);
    $display("test reset_state done");
    // sources keep requests held even after their vector is fetched
    chan_req[7'h20] = 1'b1;
    chan_req[7'h30] = 1'b1;
    tick(2);
    chkb("cpu_irq", 1'b1, cpu_irq);
    vec(vec_base + 16'h0060, 3'h1);
    tick(2);
    chkb("cpu_irq", 1'b0, cpu_irq);
    ret();
    cfg(7'h20, 8'h03);
    vec(vec_base + 16'h0040, 3'h3);
    cfg(7'h30, 8'h04);
    tick(1);
    chkb("cpu_irq", 1'b1, cpu_irq);
    vec(vec_base + 16'h0060, 3'h4);
    ret();
    ret();
    cfg(7'h20, 8'h00);
    cfg(7'h30, 8'h00);
    tick(1);
    chkb("cpu_irq", 1'b0, cpu_irq);
    vec(vec_base + OFS_SPURIOUS, 3'h0);
    cfg(7'h20, 8'h05);
    irq_mask = 1'b1;
    tick(2);
    chkb("cpu_irq", 1'b0, cpu_irq);
    irq_mask = 1'b0;
    $display("test cpu_ranking done");
    for (int i = 0; i < 7; i++) begin
      nms = 7'h00;
      nms[i] = 1'b1;
      vec(vec_base + NM_OFS[i], 3'h0);
    end
    // masked external request leaves the maskable channel to win
    nm_mask = 1'b1;
    vec(vec_base + 16'h0040, 3'h5);
    ret();
    nm_mask = 1'b0;
    nms = 7'h00;
    vec(vec_base + 16'h0040, 3'h5);
    ret();
    $display("test nonmaskable done");
    chan_req = '0;
    cfg(7'h40, 8'h85);
    chan_req[7'h40] = 1'b1;
    tick(2);
    chkb("coproc_req", 1'b1, coproc_req);
    chk("coproc_ch", 16'h0040, {9'h0, coproc_ch});
    chkb("coproc_urgent", 1'b1, coproc_urgent);
    chkb("coproc_preempt", 1'b1,
         coproc_urgent && thread_lvl < 3'h4);
    chkb("cpu_irq", 1'b0, cpu_irq);
    cfg(7'h40, 8'h83);
    tick(1);
    chkb("coproc_urgent", 1'b0, coproc_urgent);
    chkb("coproc_preempt", 1'b0,
         coproc_urgent && thread_lvl < 3'h4);
    chan_req = '0;
    cfg(7'h42, 8'h81);
    coproc_chan_flag[7'h40] = 1'b1;
    coproc_chan_flag[7'h41] = 1'b1;
    coproc_chan_flag[7'h42] = 1'b1;
    coproc_shared_priority = 3'h2;
    tick(2);
    chkb("cpu_irq", 1'b0, cpu_irq);
    coproc_irq_enable = 1'b1;
    vec(vec_base + 16'h0084, 3'h2);
    coproc_chan_flag = '0;
    ret();
    $display("test coproc done");
    // request held across the sweep, sources drop from the top
    reset_vec_req = 1'b1;
    for (int i = 0; i < 3; i++) begin
      rst_src = 3'h7 << i;
      tick(1);
      chk("cpu_vec", RST_VEC[i], cpu_vec);
      chk("reset_kind", 16'(i), {14'h0, reset_kind});
    end
    reset_vec_req = 1'b0;
    $display("test reset_vectors done");
    final_report();
  end
endmodule
`default_nettype wire
